// >>> design/tcq_pkg.sv
package tcq_pkg;
    localparam int CNT_W = 16;
    localparam int CH_N = 2;

    // clock source select codes
    localparam logic [1:0] SRC_EXT = 2'h0;
    localparam logic [1:0] SRC_AUX = 2'h1;
    localparam logic [1:0] SRC_SUB = 2'h2;
    localparam logic [1:0] SRC_INV = 2'h3;

    // control word field positions
    localparam int CTL_W = 16;
    localparam int CTL_CLR_BIT = 2;
    localparam int CTL_RUN_BIT = 4;
    localparam int CTL_DIV_LO = 6;
    localparam int CTL_DIV_HI = 7;
    localparam int CTL_SRC_LO = 8;
    localparam int CTL_SRC_HI = 9;
    localparam logic [15:0] CTL_RESET = 16'h0000;

    localparam int VEC_W = 4;
    localparam logic [3:0] VEC_NONE = 4'h0;
    // value left behind in the vector after a watchdog hit mid-update
    localparam logic [3:0] VEC_GARBLE = 4'hE;
    localparam logic [15:0] CTL_GARBLE = 16'h0310;

    localparam logic [2:0] PRESCALE_W0 = 3'h0;

    typedef enum logic [1:0] {
        PH_CLEARED = 2'b00,
        PH_RUNNING = 2'b01
    } tcq_phase_t;
endpackage : tcq_pkg

// >>> design/tcq_channel.sv
`timescale 1ns/1ps
`default_nettype none
module tcq_channel (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        wrValue,
    input  wire logic [tcq_pkg::CNT_W-1:0]   wrData,
    input  wire logic                        captureMode,
    input  wire logic                        countStep,
    input  wire logic [tcq_pkg::CNT_W-1:0]   counterValue,
    input  wire logic [tcq_pkg::CNT_W-1:0]   counterNext,
    input  wire logic                        flagClear,
    output logic                             flag_reg,
    output logic [tcq_pkg::CNT_W-1:0]        value_reg,
    output logic                             busy_reg
);
    logic suppress_reg;
    logic hit;

    // match on the value the counter is about to take
    assign hit = countStep && !captureMode && (counterNext == value_reg) && !suppress_reg;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            value_reg <= '0;
            busy_reg  <= 1'b0;
        end else begin
            busy_reg <= wrValue;
            if (wrValue) begin
                value_reg <= wrData;
            end
        end
    end

    // raising the value by one while the counter equals it silently drops the next match
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            suppress_reg <= 1'b0;
        end else if (countStep) begin
            suppress_reg <= 1'b0;
        end else if (wrValue && !captureMode && counterValue == value_reg
                     && wrData == value_reg + 16'h0001) begin
            suppress_reg <= 1'b1; // see RL1
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            flag_reg <= 1'b0;
        end else if (hit) begin
            flag_reg <= 1'b1; // see RL8
        end else if (flagClear) begin
            flag_reg <= 1'b0;
        end
    end

    a_match_sets_flag: assert property (@(posedge core_clk) disable iff (!nrst) // see RL8
        hit |=> flag_reg)
        else $error("compare match did not set flag");

    a_raise_drops_match: assert property (@(posedge core_clk) disable iff (!nrst) // see RL1
        (suppress_reg && countStep && !flag_reg) |=> !flag_reg)
        else $error("raised compare value still matched");
endmodule : tcq_channel
`default_nettype wire

// >>> design/timer_compare_counter_quirks.sv
// Operation
// RL1: raising compare by one before next count drops the following match
// RL2: software switches channel to capture around compare advances
// RL3: first count after any clear comes on first source edge
// RL4: later counts follow the divider ratio
// RL5: watchdog reset during compare update may corrupt control and vector
// RL6: software rewrites control with a full word after such a reset
// RL7: full control write clears the interrupt vector
// RL8: compare match sets the channel flag
`timescale 1ns/1ps
`default_nettype none
module timer_compare_counter_quirks (
    input  wire logic                        core_clk,
    input  wire logic                        nrst,
    input  wire logic                        extClkPin,
    input  wire logic                        auxClkPin,
    input  wire logic                        subClkPin,
    input  wire logic                        watchdogReset,
    input  wire logic                        ctlWrite,
    input  wire logic                        ctlBitSet,
    input  wire logic                        ctlBitClr,
    input  wire logic [15:0]                 ctlData,
    input  wire logic [1:0]                  chWrite,
    input  wire logic [15:0]                 chData,
    input  wire logic [1:0]                  chCapture,
    input  wire logic [1:0]                  flagClear,
    input  wire logic                        vecRead,
    output logic [15:0]                      timerControlWord,
    output logic [15:0]                      counterValue,
    output logic [3:0]                       timerIrqVector,
    output logic [1:0]                       compareFlag,
    output logic [15:0]                      chValue0,
    output logic [15:0]                      chValue1
);
    logic [1:0]  extSync_reg, auxSync_reg, subSync_reg;
    logic [15:0] ctl_reg;
    logic [15:0] cnt_reg;
    logic [15:0] cnt_next;
    logic [2:0]  pre_reg;
    logic [3:0]  vec_reg;
    logic        srcLast_reg;
    tcq_pkg::tcq_phase_t phase_reg;
    logic        srcLvl, srcRise, countStep, clearReq, anyBusy;
    logic [1:0]  flagW, busyW;
    logic [15:0] valW [2];
    logic [1:0]  divSel;
    logic [2:0]  preMax;

    function automatic logic [2:0] div_max(input logic [1:0] sel);
        case (sel)
            2'h0: div_max = 3'h0;
            2'h1: div_max = 3'h1;
            2'h2: div_max = 3'h3;
            default: div_max = 3'h7;
        endcase
    endfunction : div_max

    // two-stage synchronisers, bit 1 is the usable copy
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            extSync_reg <= 2'h0;
            auxSync_reg <= 2'h0;
            subSync_reg <= 2'h0;
        end else begin
            extSync_reg <= {extSync_reg[0], extClkPin};
            auxSync_reg <= {auxSync_reg[0], auxClkPin};
            subSync_reg <= {subSync_reg[0], subClkPin};
        end
    end

    always_comb begin
        case (ctl_reg[tcq_pkg::CTL_SRC_HI:tcq_pkg::CTL_SRC_LO])
            tcq_pkg::SRC_EXT: srcLvl = extSync_reg[1];
            tcq_pkg::SRC_AUX: srcLvl = auxSync_reg[1];
            tcq_pkg::SRC_SUB: srcLvl = subSync_reg[1];
            default:          srcLvl = ~extSync_reg[1];
        endcase
    end

    assign divSel   = ctl_reg[tcq_pkg::CTL_DIV_HI:tcq_pkg::CTL_DIV_LO];
    assign preMax   = div_max(divSel);
    assign srcRise  = srcLvl && !srcLast_reg;
    assign clearReq = ctlWrite && ctlData[tcq_pkg::CTL_CLR_BIT];
    // first edge after clear counts at once, later edges wait for divider
    assign countStep = ctl_reg[tcq_pkg::CTL_RUN_BIT] && srcRise && !clearReq
                       && (phase_reg == tcq_pkg::PH_CLEARED || pre_reg == preMax); // see RL3 see RL4
    assign cnt_next = cnt_reg + 16'h0001;
    assign anyBusy  = |busyW;

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            srcLast_reg <= 1'b0;
        end else begin
            srcLast_reg <= srcLvl;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!nrst || clearReq) begin
            cnt_reg   <= 16'h0000;
            pre_reg   <= tcq_pkg::PRESCALE_W0;
            phase_reg <= tcq_pkg::PH_CLEARED;
        end else if (ctl_reg[tcq_pkg::CTL_RUN_BIT] && srcRise) begin
            case (phase_reg)
                tcq_pkg::PH_CLEARED: begin
                    cnt_reg   <= cnt_next; // see RL3
                    phase_reg <= tcq_pkg::PH_RUNNING;
                end
                tcq_pkg::PH_RUNNING: begin
                    if (pre_reg == preMax) begin
                        pre_reg <= tcq_pkg::PRESCALE_W0;
                        cnt_reg <= cnt_next; // see RL4
                    end else begin
                        pre_reg <= pre_reg + 3'h1;
                    end
                end
                default: phase_reg <= tcq_pkg::PH_CLEARED;
            endcase
        end
    end

    // control word: watchdog hit during a compare update garbles it
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            ctl_reg <= tcq_pkg::CTL_RESET;
        end else if (watchdogReset) begin
            ctl_reg <= anyBusy ? (ctl_reg ^ tcq_pkg::CTL_GARBLE) : tcq_pkg::CTL_RESET; // see RL5
        end else if (ctlWrite) begin
            ctl_reg <= ctlData & ~(16'h0001 << tcq_pkg::CTL_CLR_BIT); // see RL6
        end else if (ctlBitSet) begin
            ctl_reg <= ctl_reg | (ctlData & ~(16'h0001 << tcq_pkg::CTL_CLR_BIT));
        end else if (ctlBitClr) begin
            ctl_reg <= ctl_reg & ~ctlData;
        end
    end

    // vector: lowest-numbered pending channel, garbled by watchdog mid-update, wiped by full write
    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            vec_reg <= tcq_pkg::VEC_NONE;
        end else if (watchdogReset) begin
            vec_reg <= anyBusy ? tcq_pkg::VEC_GARBLE : tcq_pkg::VEC_NONE; // see RL5
        end else if (ctlWrite) begin
            vec_reg <= tcq_pkg::VEC_NONE; // see RL7
        end else if (vecRead) begin
            vec_reg <= tcq_pkg::VEC_NONE;
        end else if (flagW[0]) begin
            vec_reg <= 4'h2;
        end else if (flagW[1]) begin
            vec_reg <= 4'h4;
        end
    end

    for (genvar i = 0; i < tcq_pkg::CH_N; i++) begin : g_ch
        tcq_channel u_ch (
            .core_clk     (core_clk),
            .nrst         (nrst && !watchdogReset),
            .wrValue      (chWrite[i]),
            .wrData       (chData),
            .captureMode  (chCapture[i]), // see RL2
            .countStep    (countStep),
            .counterValue (cnt_reg),
            .counterNext  (cnt_next),
            .flagClear    (flagClear[i] || (vecRead && vec_reg == 4'(2 * (i + 1)))),
            .flag_reg     (flagW[i]),
            .value_reg    (valW[i]),
            .busy_reg     (busyW[i])
        );
    end

    always_ff @(posedge core_clk) begin
        if (!nrst) begin
            timerControlWord <= 16'h0000;
            counterValue     <= 16'h0000;
            timerIrqVector   <= 4'h0;
            compareFlag      <= 2'h0;
            chValue0         <= 16'h0000;
            chValue1         <= 16'h0000;
        end else begin
            timerControlWord <= ctl_reg;
            counterValue     <= cnt_reg;
            timerIrqVector   <= vec_reg;
            compareFlag      <= flagW;
            chValue0         <= valW[0];
            chValue1         <= valW[1];
        end
    end

    // control, vector and counter checks
    a_full_write_clears: assert property (@(posedge core_clk) disable iff (!nrst) // see RL7
        (ctlWrite && !watchdogReset) |=> vec_reg == tcq_pkg::VEC_NONE)
        else $error("vector not cleared");

    a_first_count_fast: assert property (@(posedge core_clk) disable iff (!nrst) // see RL3
        (phase_reg == tcq_pkg::PH_CLEARED && ctl_reg[tcq_pkg::CTL_RUN_BIT] && srcRise && !clearReq)
        |=> cnt_reg == 16'h0001)
        else $error("first count not immediate");

    a_clear_zeroes: assert property (@(posedge core_clk) disable iff (!nrst) // see RL3
        clearReq |=> cnt_reg == 16'h0000)
        else $error("clear did not zero counter");

    a_divider_holds: assert property (@(posedge core_clk) disable iff (!nrst) // see RL4
        (ctl_reg[tcq_pkg::CTL_RUN_BIT] && srcRise && !clearReq && phase_reg == tcq_pkg::PH_RUNNING
         && pre_reg != preMax) |=> cnt_reg == $past(cnt_reg))
        else $error("counter stepped before divider end");

    a_divider_counts: assert property (@(posedge core_clk) disable iff (!nrst) // see RL4
        (ctl_reg[tcq_pkg::CTL_RUN_BIT] && srcRise && !clearReq && phase_reg == tcq_pkg::PH_RUNNING
         && pre_reg == preMax) |=> cnt_reg == $past(cnt_reg) + 16'h0001)
        else $error("counter missed divider end");

    a_stopped_holds: assert property (@(posedge core_clk) disable iff (!nrst) // see RL4
        (!ctl_reg[tcq_pkg::CTL_RUN_BIT] && !clearReq) |=> cnt_reg == $past(cnt_reg))
        else $error("stopped counter moved");

    a_watchdog_idle: assert property (@(posedge core_clk) disable iff (!nrst) // see RL5
        (watchdogReset && !anyBusy) |=> (ctl_reg == tcq_pkg::CTL_RESET && vec_reg == tcq_pkg::VEC_NONE))
        else $error("idle watchdog reset left control or vector");

    a_watchdog_garble: assert property (@(posedge core_clk) disable iff (!nrst) // see RL5
        (watchdogReset && anyBusy) |=> vec_reg == tcq_pkg::VEC_GARBLE)
        else $error("busy watchdog reset did not garble vector");
endmodule : timer_compare_counter_quirks
`default_nettype wire

// >>> verification/timer_compare_counter_quirks_test.sv
`timescale 1ns/1ps
`default_nettype none
module timer_compare_counter_quirks_test;
    logic        core_clk = 1'b0;
    logic        nrst = 1'b0;
    logic        extClkPin = 1'b0;
    logic        auxClkPin = 1'b0;
    logic        subClkPin = 1'b0;
    logic        watchdogReset = 1'b0;
    logic        ctlWrite = 1'b0;
    logic        ctlBitSet = 1'b0;
    logic        ctlBitClr = 1'b0;
    logic [15:0] ctlData = 16'h0000;
    logic [1:0]  chWrite = 2'h0;
    logic [15:0] chData = 16'h0000;
    logic [1:0]  chCapture = 2'h0;
    logic [1:0]  flagClear = 2'h0;
    logic        vecRead = 1'b0;
    logic [15:0] timerControlWord;
    logic [15:0] counterValue;
    logic [3:0]  timerIrqVector;
    logic [1:0]  compareFlag;
    logic [15:0] chValue0;
    logic [15:0] chValue1;
    int          error_cnt = 0;
    int          check_count = 0;

    timer_compare_counter_quirks i_timer_compare_counter_quirks (
        .core_clk(core_clk), .nrst(nrst), .extClkPin(extClkPin), .auxClkPin(auxClkPin),
        .subClkPin(subClkPin), .watchdogReset(watchdogReset), .ctlWrite(ctlWrite),
        .ctlBitSet(ctlBitSet), .ctlBitClr(ctlBitClr), .ctlData(ctlData), .chWrite(chWrite),
        .chData(chData), .chCapture(chCapture), .flagClear(flagClear), .vecRead(vecRead),
        .timerControlWord(timerControlWord), .counterValue(counterValue),
        .timerIrqVector(timerIrqVector), .compareFlag(compareFlag),
        .chValue0(chValue0), .chValue1(chValue1)
    );

    always #2.5 core_clk = ~core_clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : tally_and_finish

    task automatic wait_cycles(input int n);
        repeat (n) @(posedge core_clk);
    endtask : wait_cycles

    task automatic ctl_wr(input logic [15:0] d);
        ctlWrite <= 1'b1;
        ctlData  <= d;
        @(posedge core_clk);
        ctlWrite <= 1'b0;
        wait_cycles(4);
    endtask : ctl_wr

    task automatic ch_wr(input logic [1:0] mask, input logic [15:0] d);
        chWrite <= mask;
        chData  <= d;
        @(posedge core_clk);
        chWrite <= 2'h0;
        wait_cycles(4);
    endtask : ch_wr

    task automatic ctl_bit(input logic setOp, input logic [15:0] d);
        ctlBitSet <= setOp;
        ctlBitClr <= !setOp;
        ctlData   <= d;
        @(posedge core_clk);
        ctlBitSet <= 1'b0;
        ctlBitClr <= 1'b0;
        wait_cycles(4);
    endtask : ctl_bit

    // n full periods of the chosen source pin, each long enough for the sync chain
    task automatic pulse(input logic [1:0] src, input int n);
        repeat (n) begin
            if (src == tcq_pkg::SRC_SUB) begin
                subClkPin <= 1'b1;
            end else if (src == tcq_pkg::SRC_AUX) begin
                auxClkPin <= 1'b1;
            end else begin
                extClkPin <= 1'b1;
            end
            wait_cycles(8);
            subClkPin <= 1'b0;
            auxClkPin <= 1'b0;
            extClkPin <= 1'b0;
            wait_cycles(8);
        end
    endtask : pulse

    task automatic test_reset;
        check(timerControlWord, 16'h0000);
        check(counterValue, 16'h0000);
        check({12'h000, timerIrqVector}, 16'h0000);
    endtask : test_reset

    task automatic test_first_count;
        ctl_wr(16'h0294);                // clear, run, divide by 4, sub clock
        check(counterValue, 16'h0000);
        pulse(tcq_pkg::SRC_SUB, 1);
        check(counterValue, 16'h0001);
        pulse(tcq_pkg::SRC_SUB, 2);
        check(counterValue, 16'h0001);
        pulse(tcq_pkg::SRC_SUB, 2);
        check(counterValue, 16'h0002);
    endtask : test_first_count

    task automatic test_compare;
        ctl_wr(16'h0014);                // clear, run, divide by 1, ext pin
        ch_wr(2'h1, 16'h0003);
        pulse(tcq_pkg::SRC_EXT, 3);
        check({14'h0000, compareFlag}, 16'h0001);
        check({12'h000, timerIrqVector}, 16'h0002);
        flagClear <= 2'h1;
        @(posedge core_clk);
        flagClear <= 2'h0;
        wait_cycles(4);
        check({14'h0000, compareFlag}, 16'h0000);
        ch_wr(2'h1, 16'h0004);
        pulse(tcq_pkg::SRC_EXT, 1);
        check(counterValue, 16'h0004);
        check({14'h0000, compareFlag}, 16'h0000);
        chCapture <= 2'h1;
        ch_wr(2'h1, 16'h0005);
        chCapture <= 2'h0;
        wait_cycles(4);
        pulse(tcq_pkg::SRC_EXT, 1);
        check({14'h0000, compareFlag}, 16'h0001);
        vecRead <= 1'b1;
        @(posedge core_clk);
        vecRead <= 1'b0;
        wait_cycles(4);
        check({14'h0000, compareFlag}, 16'h0000);
        check({12'h000, timerIrqVector}, 16'h0000);
        check(chValue0, 16'h0005);
        ch_wr(2'h2, 16'h0006);
        pulse(tcq_pkg::SRC_EXT, 1);
        check({14'h0000, compareFlag}, 16'h0002);
        check({12'h000, timerIrqVector}, 16'h0004);
        check(chValue1, 16'h0006);
    endtask : test_compare

    task automatic test_watchdog;
        ctl_wr(16'h00D0);
        check(timerControlWord, 16'h00D0);
        chWrite <= 2'h1;
        chData  <= 16'h0009;
        @(posedge core_clk);
        chWrite       <= 2'h0;
        watchdogReset <= 1'b1;
        @(posedge core_clk);
        watchdogReset <= 1'b0;
        wait_cycles(4);
        check(timerControlWord, 16'h00D0 ^ tcq_pkg::CTL_GARBLE);
        check({12'h000, timerIrqVector}, 16'h000E);
        ctl_bit(1'b0, 16'h0300);
        check(timerControlWord, (16'h00D0 ^ tcq_pkg::CTL_GARBLE) & ~16'h0300);
        check({12'h000, timerIrqVector}, 16'h000E);
        ctl_bit(1'b1, 16'h0004);
        check(timerControlWord, (16'h00D0 ^ tcq_pkg::CTL_GARBLE) & ~16'h0300);
        check(counterValue, 16'h0006);
        ctl_wr(16'h0000);
        check(timerControlWord, 16'h0000);
        check({12'h000, timerIrqVector}, 16'h0000);
        ctl_wr(16'h00D0);
        watchdogReset <= 1'b1;
        @(posedge core_clk);
        watchdogReset <= 1'b0;
        wait_cycles(4);
        check(timerControlWord, 16'h0000);
    endtask : test_watchdog

    task automatic test_sources;
        ctl_wr(16'h0114);                // clear, run, divide by 1, aux clock
        pulse(tcq_pkg::SRC_AUX, 2);
        check(counterValue, 16'h0002);
        ctl_wr(16'h0300);                // stopped, inverted ext clock
        ctl_wr(16'h0314);                // clear, run, divide by 1, inverted ext clock
        check(counterValue, 16'h0000);
        pulse(tcq_pkg::SRC_INV, 1);
        check(counterValue, 16'h0001);
    endtask : test_sources

    initial begin
        wait_cycles(12);
        nrst <= 1'b1;
        wait_cycles(2);
        test_reset();
        test_first_count();
        test_compare();
        test_watchdog();
        test_sources();
        tally_and_finish();
    end

    initial begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end
endmodule : timer_compare_counter_quirks_test
`default_nettype wire
